// ### design/clock_gen_pkg.sv
// Shared constants, field positions and types for the clock generator
package clock_gen_pkg;

  // Register offsets on the byte-wide control port
  localparam logic [7:0] ADDR_RING_CTRL = 8'h56;
  localparam logic [7:0] ADDR_SYS_CTRL1 = 8'h57;
  localparam logic [7:0] ADDR_SYS_CTRL2 = 8'h58;

  // Values after power-up clear
  localparam logic [7:0] RST_RING_CTRL  = 8'h60;
  localparam logic [7:0] RST_SYS_CTRL1  = 8'h84;
  localparam logic [7:0] RST_SYS_CTRL2  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // Ring control fields
  localparam int STEP_LSB   = 5;
  localparam int FRAC_LSB   = 0;
  // System control 1 fields
  localparam int SECOFF_BIT = 7;
  localparam int XMODE_BIT  = 6;
  localparam int ADIV_LSB   = 4;
  localparam int RANGE_LSB  = 0;
  // System control 2 fields
  localparam int MSEL_LSB   = 6;
  localparam int MDIV_LSB   = 4;
  localparam int SSEL_BIT   = 3;
  localparam int SDIV_LSB   = 1;
  localparam int EXTRES_BIT = 0;

  localparam logic [2:0] STEP_TOP   = 3'h7;
  // Modulation period is the full wrap of this counter (32 ring cycles)
  localparam int         MOD_CNT_W  = 5;
  localparam int         SYNC_W     = 14;

  typedef enum logic [1:0] {
    SRC_RING   = 2'h0,
    SRC_SECOND = 2'h1,
    SRC_LOW    = 2'h2
  } clk_src_t;

  typedef enum logic [2:0] {
    SW_FOLLOW    = 3'h1,
    SW_WAIT_RISE = 3'h2,
    SW_WAIT_NEW  = 3'h4
  } switch_state_t;

endpackage

// ### design/clk_path_if.sv
// Source levels, select and switched level of one clock path
`timescale 1ns/10ps
interface clk_path_if;
  import clock_gen_pkg::*;
  logic     [2:0] srcLevel;
  logic     [2:0] srcDead;
  clk_src_t       sel;
  logic           outLevel;
  modport switcher (input srcLevel, input srcDead, input sel, output outLevel);
  modport user     (output srcLevel, output srcDead, output sel, input outLevel);
endinterface

// ### design/clock_switch.sv
// Glitch-free source switch for one sampled clock path
`timescale 1ns/10ps
module clock_switch (
  input wire logic     sys_clk,
  input wire logic     rst_b,
  clk_path_if.switcher path
);
  import clock_gen_pkg::*;

  switch_state_t stateReg;
  clk_src_t      curSelReg;
  clk_src_t      newSelReg;
  logic [2:0]    prevLevelReg;
  logic          outReg;
  logic [2:0]    rise;

  assign rise          = path.srcLevel & ~prevLevelReg;
  assign path.outLevel = outReg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevLevelReg <= 3'h0;
    end else begin
      prevLevelReg <= path.srcLevel;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg  <= SW_FOLLOW;
      curSelReg <= SRC_RING;
      newSelReg <= SRC_RING;
      outReg    <= 1'b0;
    end else begin
      unique case (stateReg)
        SW_FOLLOW: begin
          outReg <= path.srcLevel[curSelReg];
          if (path.sel != curSelReg) begin
            newSelReg <= path.sel;
            stateReg  <= SW_WAIT_RISE;
          end
        end
        SW_WAIT_RISE: begin
          // Finish the running cycle; a dead source would never give its edge
          outReg    <= path.srcLevel[curSelReg];
          newSelReg <= path.sel;
          if (rise[curSelReg] || path.srcDead[curSelReg]) begin
            outReg   <= 1'b1;
            stateReg <= SW_WAIT_NEW;
          end
        end
        SW_WAIT_NEW: begin
          outReg <= 1'b1;
          if (rise[newSelReg]) begin
            curSelReg <= newSelReg;
            stateReg  <= SW_FOLLOW;
          end else begin
            // Track a later select so a source stopped meanwhile cannot hang the path
            newSelReg <= path.sel;
          end
        end
        default: begin
          stateReg <= SW_FOLLOW;
        end
      endcase
    end
  end

  chk_switch_hold_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (stateReg == SW_WAIT_NEW) |=> outReg)
    else $error("switched clock dropped low while waiting for new source");

  chk_switch_commit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (stateReg == SW_WAIT_NEW && rise[newSelReg]) |=>
      (curSelReg == $past(newSelReg) && stateReg == SW_FOLLOW))
    else $error("switch did not commit on new source rising edge");

endmodule // clock_switch

// ### design/clock_divider.sv
// Power-of-two divider on a sampled clock level
`timescale 1ns/10ps
module clock_divider (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       inLevel,
  input  wire logic [1:0] divSel,
  output logic            outLevel
);
  import clock_gen_pkg::*;

  logic       prevReg;
  logic [2:0] cntReg;
  logic [2:0] cntNext;
  logic       outReg;
  logic [1:0] selReg;
  logic [1:0] useSel;
  logic       wrapRise;

  assign cntNext  = (inLevel && !prevReg) ? cntReg + 3'h1 : cntReg;
  assign wrapRise = inLevel && !prevReg && (cntNext == 3'h0);
  assign useSel   = wrapRise ? divSel : selReg;
  assign outLevel = outReg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevReg <= 1'b0;
      cntReg  <= 3'h0;
    end else begin
      prevReg <= inLevel;
      cntReg  <= cntNext;
    end
  end

  // Ratio changes wait for the counter wrap, where no ratio cuts a pulse short
  // Limitation: a stopped source keeps its old ratio until it runs again
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      selReg <= 2'h0;
      outReg <= 1'b0;
    end else begin
      selReg <= useSel;
      unique case (useSel)
        2'h0: outReg <= inLevel;
        2'h1: outReg <= cntNext[0];
        2'h2: outReg <= cntNext[1];
        2'h3: outReg <= cntNext[2];
      endcase
    end
  end

  chk_div_bypass: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (useSel == 2'h0) |=> (outReg == $past(inLevel)))
    else $error("divide-by-one output does not follow input");

  chk_div_half: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (useSel == 2'h1 && inLevel && !prevReg) |=> (outReg != $past(cntReg[0])))
    else $error("divide-by-two output missed a source rising edge");

endmodule // clock_divider

// ### design/basic_clock_generator.sv
// Clock generator top: control registers, source select, dividers, ring control
`timescale 1ns/10ps
module basic_clock_generator #(
  parameter bit HAS_SECOND_OSC = 1'b1
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       lowOscClk,
  input  wire logic       secondOscClk,
  input  wire logic [7:0] ringStepClk,
  input  wire logic       lowOscOff,
  input  wire logic       ringOscOff,
  input  wire logic       lowOscFault,
  input  wire logic       secondOscFault,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  output logic            auxClk,
  output logic            mainClk,
  output logic            subMainClk,
  output logic            lowOscEn,
  output logic            secondOscEn,
  output logic            ringOscEn,
  output logic            crystalModeSel,
  output logic            extResistorSel,
  output logic      [2:0] rangeSel,
  output logic      [2:0] ringStepSel
);
  import clock_gen_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  function automatic clk_src_t mapSel(input logic [1:0] code);
    unique case (code)
      2'h0, 2'h1: mapSel = SRC_RING;
      2'h2:       mapSel = HAS_SECOND_OSC ? SRC_SECOND : SRC_LOW;
      default:    mapSel = SRC_LOW;
    endcase
  endfunction

  logic [SYNC_W-1:0]    sync1Reg;
  logic [SYNC_W-1:0]    sync2Reg;
  logic [7:0]           ringCtrlReg;
  logic [7:0]           sysCtrl1Reg;
  logic [7:0]           sysCtrl2Reg;
  logic [7:0]           rdDataReg;
  logic [MOD_CNT_W-1:0] modCntReg;
  logic [2:0]           ringStepSelReg;
  logic                 ringPrevReg;
  logic                 lowOscEnReg;
  logic                 secondOscEnReg;
  logic                 ringOscEnReg;

  logic [7:0] stepLevelS;
  logic       lowLevelS;
  logic       secondLevelS;
  logic       lowOffS;
  logic       ringOffS;
  logic       lowFaultS;
  logic       secondFaultS;
  logic       ringLevel;
  logic [2:0] freqStep;
  logic [4:0] fraction;
  logic       xMode;
  clk_src_t   mainReq;
  clk_src_t   mainEff;
  clk_src_t   subEff;
  logic       mainFault;
  logic       useHigher;
  logic       usedLow;
  logic       usedSecond;
  logic       usedRing;
  logic [2:0] srcLevels;
  logic [2:0] srcDeads;
  logic       auxDiv;
  logic       mainDiv;
  logic       subDiv;

  clk_path_if mainPath ();
  clk_path_if subPath ();

  // Oscillator clocks and status levels come from other domains
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1Reg <= '0;
      sync2Reg <= '0;
    end else begin
      sync1Reg <= {ringStepClk, lowOscClk, secondOscClk,
                   lowOscOff, ringOscOff, lowOscFault, secondOscFault};
      sync2Reg <= sync1Reg;
    end
  end

  assign stepLevelS   = sync2Reg[13:6];
  assign lowLevelS    = sync2Reg[5];
  assign secondLevelS = HAS_SECOND_OSC ? sync2Reg[4] : 1'b0;
  assign lowOffS      = sync2Reg[3];
  assign ringOffS     = sync2Reg[2];
  assign lowFaultS    = sync2Reg[1];
  assign secondFaultS = HAS_SECOND_OSC ? sync2Reg[0] : 1'b0;

  // Register writes take effect on the next edge, whatever the clocks do
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ringCtrlReg <= RST_RING_CTRL;
      sysCtrl1Reg <= RST_SYS_CTRL1;
      sysCtrl2Reg <= RST_SYS_CTRL2;
    end else if (wrStrobe) begin
      if (addr == ADDR_RING_CTRL) ringCtrlReg <= wrData;
      if (addr == ADDR_SYS_CTRL1) sysCtrl1Reg <= wrData;
      if (addr == ADDR_SYS_CTRL2) sysCtrl2Reg <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataReg <= READ_UNMAPPED;
    end else if (rdStrobe) begin
      unique case (addr)
        ADDR_RING_CTRL: rdDataReg <= ringCtrlReg;
        ADDR_SYS_CTRL1: rdDataReg <= sysCtrl1Reg;
        ADDR_SYS_CTRL2: rdDataReg <= sysCtrl2Reg;
        default:        rdDataReg <= READ_UNMAPPED;
      endcase
    end else begin
      rdDataReg <= READ_UNMAPPED;
    end
  end

  assign rdData         = rdDataReg;
  assign freqStep       = ringCtrlReg[STEP_LSB +: 3];
  assign fraction       = ringCtrlReg[FRAC_LSB +: 5];
  assign xMode          = sysCtrl1Reg[XMODE_BIT];
  assign crystalModeSel = sysCtrl1Reg[XMODE_BIT];
  assign rangeSel       = sysCtrl1Reg[RANGE_LSB +: 3];
  assign extResistorSel = sysCtrl2Reg[EXTRES_BIT];

  // Source selection with variant substitution; fault failover on the main path only
  assign mainReq   = mapSel(sysCtrl2Reg[MSEL_LSB +: 2]);
  assign mainFault = (mainReq == SRC_SECOND && secondFaultS) ||
                     (mainReq == SRC_LOW && xMode && lowFaultS);
  assign mainEff   = mainFault ? SRC_RING : mainReq;
  assign subEff    = mapSel({sysCtrl2Reg[SSEL_BIT], 1'b0});

  assign usedLow    = (mainEff == SRC_LOW) || (subEff == SRC_LOW);
  assign usedSecond = (mainEff == SRC_SECOND) || (subEff == SRC_SECOND);
  assign usedRing   = (mainEff == SRC_RING) || (subEff == SRC_RING);

  // Oscillators stay on while selected, whatever the off request says
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowOscEnReg    <= 1'b1;
      secondOscEnReg <= 1'b0;
      ringOscEnReg   <= 1'b1;
    end else begin
      lowOscEnReg    <= !(lowOffS && !usedLow);
      secondOscEnReg <= HAS_SECOND_OSC && !(sysCtrl1Reg[SECOFF_BIT] && !usedSecond);
      ringOscEnReg   <= !(ringOffS && !usedRing);
    end
  end

  assign lowOscEn    = lowOscEnReg;
  assign secondOscEn = secondOscEnReg;
  assign ringOscEn   = ringOscEnReg;

  // Modulator: the step input currently selected is the ring clock
  assign ringLevel = stepLevelS[ringStepSelReg];
  assign useHigher = (modCntReg < fraction) && (freqStep != STEP_TOP);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ringPrevReg <= 1'b0;
      modCntReg   <= '0;
    end else begin
      ringPrevReg <= ringLevel;
      if (ringLevel && !ringPrevReg) begin
        modCntReg <= modCntReg + 5'h01;
      end
    end
  end

  // Step moves only between ring cycles; a step change can still clip one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ringStepSelReg <= RST_RING_CTRL[STEP_LSB +: 3];
    end else begin
      ringStepSelReg <= freqStep + {2'h0, useHigher};
    end
  end

  assign ringStepSel = ringStepSelReg;

  // Path sources indexed by clk_src_t
  assign srcLevels = {lowLevelS, secondLevelS, ringLevel};
  // A stopped or faulted source never rises, so the switch must not wait on it
  assign srcDeads  = {(xMode && lowFaultS) || !lowOscEnReg,
                      secondFaultS || !secondOscEnReg,
                      !ringOscEnReg};

  assign mainPath.srcLevel = srcLevels;
  assign mainPath.srcDead  = srcDeads;
  assign mainPath.sel      = mainEff;
  assign subPath.srcLevel  = srcLevels;
  assign subPath.srcDead   = srcDeads;
  assign subPath.sel       = subEff;

  clock_switch mainSwitch (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .path    (mainPath)
  );

  clock_switch subSwitch (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .path    (subPath)
  );

  clock_divider auxDivider (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inLevel  (lowLevelS),
    .divSel   (sysCtrl1Reg[ADIV_LSB +: 2]),
    .outLevel (auxDiv)
  );

  clock_divider mainDivider (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inLevel  (mainPath.outLevel),
    .divSel   (sysCtrl2Reg[MDIV_LSB +: 2]),
    .outLevel (mainDiv)
  );

  clock_divider subDivider (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .inLevel  (subPath.outLevel),
    .divSel   (sysCtrl2Reg[SDIV_LSB +: 2]),
    .outLevel (subDiv)
  );

  assign auxClk     = auxDiv;
  assign mainClk    = mainDiv;
  assign subMainClk = subDiv;

  chk_write_takes_effect: assert property (
    (wrStrobe && addr == ADDR_RING_CTRL) |=> (ringCtrlReg == $past(wrData)))
    else $error("ring control write not applied");

  chk_read_one_cycle: assert property (
    (rdStrobe && addr == ADDR_SYS_CTRL1 && !wrStrobe) |=>
      (rdData == $past(sysCtrl1Reg)) ##1 (rdData == READ_UNMAPPED || $past(rdStrobe)))
    else $error("read data not presented in the following cycle only");

  chk_fault_failover: assert property (
    (mainReq == SRC_SECOND && secondFaultS) |-> (mainEff == SRC_RING))
    else $error("faulted second oscillator still drives main clock");

  chk_variant_subst: assert property (
    (!HAS_SECOND_OSC) |-> (mainEff != SRC_SECOND && subEff != SRC_SECOND))
    else $error("absent second oscillator selected");

  chk_low_osc_kept: assert property (
    usedLow |=> lowOscEn)
    else $error("crystal stopped while sourcing a clock");

  chk_second_osc_kept: assert property (
    (usedSecond && HAS_SECOND_OSC) |=> secondOscEn)
    else $error("second oscillator stopped while in use");

  chk_ring_osc_state: assert property (
    (ringOffS && !usedRing) |=> !ringOscEn)
    else $error("ring oscillator not stopped when unused and off");

  chk_mod_top_step: assert property (
    (freqStep == STEP_TOP) |=> (ringStepSel == STEP_TOP))
    else $error("modulator raised step beyond top");

  chk_mod_off_zero: assert property (
    (fraction == 5'h00) |=> (ringStepSel == $past(freqStep)))
    else $error("modulator active with zero fraction");

endmodule // basic_clock_generator

// ### verif/osc_bank_model.sv
// Oscillator bank feeding the clock generator: crystal, second, ring steps
`timescale 1ns/10ps
module osc_bank_model #(
  parameter real LOW_P = 163.0,
  parameter real SEC_P = 247.0
) (
  input  wire logic       lowEn,
  input  wire logic       secEn,
  input  wire logic       ringEn,
  output logic            lowClk,
  output logic            secClk,
  output wire logic [7:0] ringClk
);
  // A stopped oscillator stands still low, never keeps toggling
  initial begin
    lowClk = 1'b0;
    forever #(LOW_P / 2.0) lowClk = lowEn ? ~lowClk : 1'b0;
  end
  initial begin
    secClk = 1'b0;
    forever #(SEC_P / 2.0) secClk = secEn ? ~secClk : 1'b0;
  end
  for (genvar i = 0; i < 8; i++) begin : g_step
    logic c;
    initial begin
      c = 1'b0;
      forever #((201.0 + 20.0 * i) / 2.0) c = ringEn ? ~c : 1'b0;
    end
    assign ringClk[i] = c;
  end
endmodule // osc_bank_model

// ### verif/tb.sv
// Self-checking bench for the clock generator
`timescale 1ns/10ps
module tb;
  import clock_gen_pkg::*;
  localparam int  WIN   = 2000;
  localparam real LOW_P = 163.0;
  localparam real SEC_P = 247.0;
  logic       sys_clk, rst_b, lowOscClk, secondOscClk, lowOscOff, ringOscOff;
  logic       lowOscFault, secondOscFault, wrStrobe, rdStrobe, auxClk, mainClk;
  logic       subMainClk, lowOscEn, secondOscEn, ringOscEn, crystalModeSel, extResistorSel;
  logic [2:0] rangeSel, ringStepSel;
  logic [7:0] ringStepClk, addr, wrData, rdData, d0, d1, d2;
  logic [1:0] dv;
  int         nErrors, checked;
  logic       varMainClk;

  basic_clock_generator u_basic_clock_generator (
    .sys_clk(sys_clk), .rst_b(rst_b), .lowOscClk(lowOscClk), .secondOscClk(secondOscClk),
    .ringStepClk(ringStepClk), .lowOscOff(lowOscOff), .ringOscOff(ringOscOff),
    .lowOscFault(lowOscFault), .secondOscFault(secondOscFault), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .auxClk(auxClk), .mainClk(mainClk), .subMainClk(subMainClk), .lowOscEn(lowOscEn),
    .secondOscEn(secondOscEn), .ringOscEn(ringOscEn), .crystalModeSel(crystalModeSel),
    .extResistorSel(extResistorSel), .rangeSel(rangeSel), .ringStepSel(ringStepSel));
  osc_bank_model #(.LOW_P(LOW_P), .SEC_P(SEC_P)) u_osc_bank_model (
    .lowEn(lowOscEn), .secEn(secondOscEn), .ringEn(ringOscEn),
    .lowClk(lowOscClk), .secClk(secondOscClk), .ringClk(ringStepClk));
  // Variant without the second oscillator, fed the same stimulus
  if (1) begin : g_variant
    basic_clock_generator #(.HAS_SECOND_OSC(1'b0)) u_basic_clock_generator (
      .sys_clk(sys_clk), .rst_b(rst_b), .lowOscClk(lowOscClk), .secondOscClk(secondOscClk),
      .ringStepClk(ringStepClk), .lowOscOff(lowOscOff), .ringOscOff(ringOscOff),
      .lowOscFault(lowOscFault), .secondOscFault(secondOscFault), .addr(addr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(),
      .auxClk(), .mainClk(varMainClk), .subMainClk(), .lowOscEn(), .secondOscEn(),
      .ringOscEn(), .crystalModeSel(), .extResistorSel(), .rangeSel(), .ringStepSel());
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic real ringP(input int s);
    return 201.0 + 20.0 * s;
  endfunction
  function automatic real mainP(input logic [1:0] s);
    return (s[1] == 1'b0) ? ringP(3) : (s[0] ? LOW_P : SEC_P);
  endfunction

  task automatic conclude();
    if (nErrors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] got);
    checked++;
    if (got !== e) begin
      $display("[ERR] %s expected %h seen %h", what, e, got);
      nErrors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge sys_clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
    @(negedge sys_clk);
    cmp("rdData", e, rdData);
  endtask

  // Enables settle within two sync stages plus one register
  task automatic en(input logic [2:0] e);
    repeat (8) @(negedge sys_clk);
    cmp("enables", {5'h0, e}, {5'h0, lowOscEn, secondOscEn, ringOscEn});
  endtask

  // Counts rises and shortest pulse; a switch glitch shows as a short pulse
  task automatic meas(input int which, input real per, input int div, input string what);
    int   n, run, minRun, seen;
    logic prev, cur;
    real  e;
    n = 0;
    run = 0;
    minRun = 1000;
    seen = 0;
    repeat (400) @(negedge sys_clk);
    prev = (which == 0) ? auxClk : (which == 1) ? mainClk :
           (which == 2) ? subMainClk : varMainClk;
    repeat (WIN) begin
      @(negedge sys_clk);
      cur = (which == 0) ? auxClk : (which == 1) ? mainClk :
            (which == 2) ? subMainClk : varMainClk;
      if (cur !== prev) begin
        if (seen && run < minRun) minRun = run;
        seen = 1;
        run = 0;
        if (cur === 1'b1) n++;
      end
      run++;
      prev = cur;
    end
    e = WIN * 10.0 / (per * div);
    checked++;
    if (n < e - 1.0 || n > e + 1.0 || minRun < 5) begin
      $display("[ERR] %s expected %0d rises seen %0d pulse %0d", what, int'(e), n, minRun);
      nErrors++;
    end
  endtask

  // Applied step must be the set step, or the next one while mixing
  task automatic stepWatch(input logic [7:0] rc);
    logic [2:0] st;
    int         hi;
    st = rc[7:5];
    hi = 0;
    repeat (80) @(negedge sys_clk);
    repeat (1400) begin
      @(negedge sys_clk);
      if (ringStepSel !== st) begin
        hi++;
        cmp("ringStepSel", {5'h0, st + 3'h1}, {5'h0, ringStepSel});
      end
    end
    checked++;
    if ((hi > 0) !== (rc[4:0] != 5'h0 && st != 3'h7)) begin
      $display("[ERR] step mixing expected %0d seen %0d", rc[4:0] != 5'h0 && st != 3'h7, hi > 0);
      nErrors++;
    end
  endtask

  initial begin
    #800000;
    nErrors++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    {lowOscOff, ringOscOff, lowOscFault, secondOscFault, wrStrobe, rdStrobe} = 6'h00;
    addr = 8'h00;
    wrData = 8'h00;
    nErrors = 0;
    checked = 0;
    d0 = 8'($urandom(3));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    cmp("rangeSel", 8'h04, {5'h0, rangeSel});
    cmp("ringStepSel", 8'h03, {5'h0, ringStepSel});
    cmp("extResistorSel", 8'h00, {7'h0, extResistorSel});
    cmp("crystalModeSel", 8'h00, {7'h0, crystalModeSel});
    en(3'b101);
    rdChk(ADDR_RING_CTRL, 8'h60);
    rdChk(ADDR_SYS_CTRL1, 8'h84);
    rdChk(ADDR_SYS_CTRL2, 8'h00);
    meas(1, ringP(3), 1, "mainClk");
    meas(2, ringP(3), 1, "subMainClk");
    meas(0, LOW_P, 1, "auxClk");
    for (int i = 0; i < 8; i++) begin
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      if (i == 0) d0 = 8'he5;
      if (i == 1) d0 = 8'h40;
      wr(ADDR_RING_CTRL, d0);
      wr(ADDR_SYS_CTRL1, d1);
      wr(ADDR_SYS_CTRL2, d2);
      wr(8'h55, 8'hff);
      rdChk(ADDR_RING_CTRL, d0);
      rdChk(ADDR_SYS_CTRL1, d1);
      rdChk(ADDR_SYS_CTRL2, d2);
      rdChk(8'h59, 8'h00);
      cmp("extResistorSel", {7'h0, d2[0]}, {7'h0, extResistorSel});
      cmp("rangeSel", {5'h0, d1[2:0]}, {5'h0, rangeSel});
      cmp("crystalModeSel", {7'h0, d1[6]}, {7'h0, crystalModeSel});
      stepWatch(d0);
    end
    wr(ADDR_RING_CTRL, 8'h60);
    wr(ADDR_SYS_CTRL1, 8'h84);
    wr(ADDR_SYS_CTRL2, 8'h00);
    @(posedge sys_clk);
    lowOscOff <= 1'b1;
    en(3'b001);
    wr(ADDR_SYS_CTRL2, 8'hc0);
    en(3'b101);
    @(posedge sys_clk);
    ringOscOff <= 1'b1;
    en(3'b101);
    wr(ADDR_SYS_CTRL2, 8'hc8);
    en(3'b110);
    wr(ADDR_SYS_CTRL2, 8'hc0);
    en(3'b101);
    @(posedge sys_clk);
    lowOscOff <= 1'b0;
    ringOscOff <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_SYS_CTRL1, {2'b00, 2'(d), 4'h4});
      meas(0, LOW_P, 1 << d, "auxClk");
    end
    for (int s = 0; s < 4; s++) begin
      dv = 2'($urandom);
      if (s == 3) dv = 2'h3;
      wr(ADDR_SYS_CTRL2, {2'(s), dv, 1'b1, 2'(s), 1'b0});
      meas(1, mainP(2'(s)), 1 << dv, "mainClk");
      meas(2, SEC_P, 1 << s, "subMainClk");
      if (s == 2) meas(3, LOW_P, 1 << dv, "varMainClk");
    end
    wr(ADDR_SYS_CTRL1, 8'h44);
    wr(ADDR_SYS_CTRL2, 8'hc0);
    meas(1, LOW_P, 1, "mainClk");
    @(posedge sys_clk);
    lowOscFault <= 1'b1;
    meas(1, ringP(3), 1, "mainClk");
    @(posedge sys_clk);
    lowOscFault <= 1'b0;
    wr(ADDR_SYS_CTRL2, 8'h80);
    meas(1, SEC_P, 1, "mainClk");
    @(posedge sys_clk);
    secondOscFault <= 1'b1;
    meas(1, ringP(3), 1, "mainClk");
    @(posedge sys_clk);
    secondOscFault <= 1'b0;
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdChk(ADDR_SYS_CTRL2, 8'h00);
    rdChk(ADDR_SYS_CTRL1, 8'h84);
    conclude();
  end
endmodule // tb
